// ==== logic/rhc_cfg.svh ====
// Constants for the RS-232 handshake and session controller
// Notes on behaviour
// - No hardware handshake: control lines up, inputs ignored.
// - Full handshake: transfers need both terminal ready and set ready.
// - Full handshake: raise RTS, send after CTS.
// - Drop RTS once transmission has finished.
// - Re-raise RTS only after CTS, carrier drop.
// - Accept characters only with carrier, RTS low.
// - ENQ before each block, send after ACK.
// - Return ACK only with room for block.
// - Send XOFF when buffer reaches 32 characters.
// - Send XON when buffer drains to ten.
// - XON/XOFF allowed only in full duplex.
// - At most two characters sent after XOFF; the pause holds only user data, echo and status text still go out.
// - Echo on/off commands; full duplex echoes immediately.
// - Half duplex echo waits for ENQ or LF.
// - Reset clears echo and lockout.
// - Lockout commands block and release other inputs; the controller only drives o_lockout and blocks nothing itself.
// - Error bits zero to six accumulate by OR.
// - Status query returns header, padded decimal, CR LF.
// - Reading the status word clears it.
// - Receive buffer holds 128 characters.
`ifndef RHC_CFG_SVH
`define RHC_CFG_SVH

`define RHC_BUF_DEPTH 128
`define RHC_BLOCK_LEN 96
`define RHC_XOFF_LEVEL 32
`define RHC_XON_LEVEL 10

`define RHC_CH_ENQ 8'h05
`define RHC_CH_ACK 8'h06
`define RHC_CH_XON 8'h11
`define RHC_CH_XOFF 8'h13
`define RHC_CH_LF 8'h0A
`define RHC_CH_CR 8'h0D
`define RHC_CH_SP 8'h20
`define RHC_CH_ZERO 8'h30

`define RHC_HDR_0 8'h53
`define RHC_HDR_1 8'h54
`define RHC_HDR_2 8'h53
`define RHC_HDR_3 8'h57
`define RHC_HDR_4 8'h44
`define RHC_FMT_LAST 4'hA

`define RHC_ST_KEYCODE 0
`define RHC_ST_LOCKED 1
`define RHC_ST_LINK 2
`define RHC_ST_PANEL 3
`define RHC_ST_OVERRUN 4
`define RHC_ST_PARITY 5
`define RHC_ST_FRAMING 6
`define RHC_ST_RESET 8'h00

`endif

// ==== logic/rhc_ctrl.sv ====
// RS-232 handshake, flow control, echo, lockout and status controller
`timescale 1ns/1ps
`default_nettype none
`include "rhc_cfg.svh"
module rhc_ctrl #(
  parameter int DEPTH = `RHC_BUF_DEPTH,
  parameter int BLOCK = `RHC_BLOCK_LEN,
  parameter int XOFF_LVL = `RHC_XOFF_LEVEL,
  parameter int XON_LVL = `RHC_XON_LEVEL
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hs_full,
  input wire logic [1:0] i_sw_mode,
  input wire logic i_full_duplex,
  input wire logic i_ready,
  input wire logic i_dsr,
  input wire logic i_cts,
  input wire logic i_cd,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_char,
  input wire logic i_rx_parity_err,
  input wire logic i_rx_frame_err,
  input wire logic i_txu_ready,
  input wire logic i_txu_idle,
  output logic o_txu_valid,
  output logic [7:0] o_txu_char,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_char,
  output logic o_tx_ack,
  output logic o_rd_valid,
  output logic [7:0] o_rd_char,
  input wire logic i_rd_ready,
  input wire logic i_cmd_echo_on,
  input wire logic i_cmd_echo_off,
  input wire logic i_cmd_lock_on,
  input wire logic i_cmd_lock_off,
  input wire logic i_cmd_status,
  input wire logic i_err_keycode,
  input wire logic i_err_locked,
  input wire logic i_err_link,
  input wire logic i_err_panel,
  output logic o_dtr,
  output logic o_rts,
  output logic o_lockout,
  output logic o_echo
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] ACK_ROOM = CW'(DEPTH - BLOCK);
  localparam logic [CW-1:0] XOFF_CNT = CW'(XOFF_LVL);
  localparam logic [CW-1:0] XON_CNT = CW'(XON_LVL);
  localparam logic [7:0] BLK_LAST = 8'(BLOCK - 1);

  typedef struct packed {
    logic [1:0] dsr_s;
    logic [1:0] cts_s;
    logic [1:0] cd_s;
    logic dtr;
    logic rts;
    rhc_pkg::rhc_hs_e hs;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] ech_ptr;
    logic [CW-1:0] count;
    logic rd_valid;
    logic [7:0] rd_char;
    logic txu_valid;
    logic [7:0] txu_char;
    logic tx_ack;
    logic echo;
    logic echo_rel;
    logic lockout;
    logic ack_pend;
    logic xoff_sent;
    logic paused;
    logic granted;
    logic enq_sent;
    logic [7:0] blk_cnt;
    logic [7:0] status;
    logic fmt_start;
    logic [7:0] fmt_value;
  } rhc_state_s;

  rhc_state_s q;
  rhc_state_s d;
  logic [7:0] mem [DEPTH];
  logic wr_en;
  logic take_fmt;
  logic rx_ok;
  logic tx_ok;
  logic slot;
  logic xon_mode;
  logic enq_mode;
  logic need_xoff;
  logic need_xon;
  logic ack_ok;
  logic ech_av;
  logic usr_av;
  logic enq_need;
  logic usr_go;
  logic pending;
  logic cnt_inc;
  logic cnt_dec;

  rhc_fmt_if fif ();

  rhc_status_fmt u_fmt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .fif(fif.fmt)
  );

  assign fif.start = q.fmt_start;
  assign fif.value = q.fmt_value;
  assign fif.take = take_fmt;

  // Receive gate: carrier, own RTS low and both ready lines in full mode
  assign rx_ok = !i_hs_full || (q.cd_s[1] && !q.rts && q.dsr_s[1] && q.dtr);
  // Without hardware handshake the modem lines are don't care
  assign tx_ok = !i_hs_full ||
    (q.hs == rhc_pkg::RHC_HS_SEND && q.cts_s[1] && q.dsr_s[1] && q.dtr);
  assign slot = !q.txu_valid || i_txu_ready;
  assign xon_mode = (i_sw_mode == rhc_pkg::RHC_SW_XON) && i_full_duplex;
  assign enq_mode = (i_sw_mode == rhc_pkg::RHC_SW_ENQ);
  assign need_xoff = xon_mode && !q.xoff_sent && q.count >= XOFF_CNT;
  assign need_xon = xon_mode && q.xoff_sent && q.count <= XON_CNT;
  assign ack_ok = q.ack_pend && q.count <= ACK_ROOM;
  assign ech_av = q.echo && (i_full_duplex || q.echo_rel) && q.ech_ptr != q.wr_ptr;
  // The tx_ack term stops a second take while the host still shows the old char
  assign usr_av = i_tx_valid && !q.tx_ack && !(xon_mode && q.paused);
  assign enq_need = enq_mode && usr_av && !q.granted && !q.enq_sent;
  assign usr_go = usr_av && (!enq_mode || q.granted);
  assign pending = need_xoff || need_xon || ack_ok || fif.valid || ech_av ||
    enq_need || usr_go;

  always_comb
  begin
    d = q;
    wr_en = 1'b0;
    take_fmt = 1'b0;
    cnt_inc = 1'b0;
    cnt_dec = 1'b0;
    d.dsr_s = {q.dsr_s[0], i_dsr};
    d.cts_s = {q.cts_s[0], i_cts};
    d.cd_s = {q.cd_s[0], i_cd};
    d.tx_ack = 1'b0;
    d.fmt_start = 1'b0;
    d.dtr = i_hs_full ? i_ready : 1'b1;

    // Clears come first so that a same-cycle set below wins
    if (q.echo && !i_full_duplex && q.echo_rel && q.ech_ptr == q.wr_ptr)
    begin
      d.echo_rel = 1'b0;
    end
    if (i_cmd_status && !fif.valid && !q.fmt_start)
    begin
      d.fmt_start = 1'b1;
      d.fmt_value = q.status;
      d.status = `RHC_ST_RESET;
    end

    // Transmit arbitration: flow control first, user data last
    if (q.txu_valid && i_txu_ready)
    begin
      d.txu_valid = 1'b0;
    end
    if (slot && tx_ok)
    begin
      if (need_xoff)
      begin
        d.txu_valid = 1'b1;
        d.txu_char = `RHC_CH_XOFF;
        d.xoff_sent = 1'b1;
      end
      else if (need_xon)
      begin
        d.txu_valid = 1'b1;
        d.txu_char = `RHC_CH_XON;
        d.xoff_sent = 1'b0;
      end
      else if (ack_ok)
      begin
        d.txu_valid = 1'b1;
        d.txu_char = `RHC_CH_ACK;
        d.ack_pend = 1'b0;
      end
      else if (fif.valid)
      begin
        d.txu_valid = 1'b1;
        d.txu_char = fif.chr;
        take_fmt = 1'b1;
      end
      else if (ech_av)
      begin
        d.txu_valid = 1'b1;
        d.txu_char = mem[q.ech_ptr];
        d.ech_ptr = q.ech_ptr + 1'b1;
      end
      else if (enq_need)
      begin
        d.txu_valid = 1'b1;
        d.txu_char = `RHC_CH_ENQ;
        d.enq_sent = 1'b1;
      end
      else if (usr_go)
      begin
        d.txu_valid = 1'b1;
        d.txu_char = i_tx_char;
        d.tx_ack = 1'b1;
        if (enq_mode)
        begin
          d.blk_cnt = q.blk_cnt + 8'h01;
          if (q.blk_cnt == BLK_LAST)
          begin
            d.granted = 1'b0;
            d.enq_sent = 1'b0;
          end
        end
      end
    end

    // Receive side
    if (i_rx_valid && rx_ok)
    begin
      if (i_rx_parity_err)
      begin
        d.status[`RHC_ST_PARITY] = 1'b1;
      end
      if (i_rx_frame_err)
      begin
        d.status[`RHC_ST_FRAMING] = 1'b1;
      end
      if (xon_mode && i_rx_char == `RHC_CH_XOFF)
      begin
        d.paused = 1'b1;
      end
      else if (xon_mode && i_rx_char == `RHC_CH_XON)
      begin
        d.paused = 1'b0;
      end
      else if (enq_mode && i_rx_char == `RHC_CH_ENQ)
      begin
        d.ack_pend = 1'b1;
        if (q.echo && !i_full_duplex)
        begin
          d.echo_rel = 1'b1;
        end
      end
      else if (enq_mode && i_rx_char == `RHC_CH_ACK)
      begin
        d.granted = 1'b1;
        d.enq_sent = 1'b0;
        d.blk_cnt = 8'h00;
      end
      else if (q.count == FULL_CNT)
      begin
        d.status[`RHC_ST_OVERRUN] = 1'b1;
      end
      else
      begin
        wr_en = 1'b1;
        d.wr_ptr = q.wr_ptr + 1'b1;
        cnt_inc = 1'b1;
        if (q.echo && !i_full_duplex && !enq_mode && i_rx_char == `RHC_CH_LF)
        begin
          d.echo_rel = 1'b1;
        end
      end
    end

    // Buffer read-out toward the command interpreter
    if (!q.rd_valid || i_rd_ready)
    begin
      d.rd_valid = 1'b0;
      if (q.count != '0)
      begin
        d.rd_valid = 1'b1;
        d.rd_char = mem[q.rd_ptr];
        d.rd_ptr = q.rd_ptr + 1'b1;
        cnt_dec = 1'b1;
      end
    end
    if (cnt_inc && !cnt_dec)
    begin
      d.count = q.count + 1'b1;
    end
    else if (!cnt_inc && cnt_dec)
    begin
      d.count = q.count - 1'b1;
    end

    // Error events from the rest of the instrument accumulate
    if (i_err_keycode)
    begin
      d.status[`RHC_ST_KEYCODE] = 1'b1;
    end
    if (i_err_locked)
    begin
      d.status[`RHC_ST_LOCKED] = 1'b1;
    end
    if (i_err_link)
    begin
      d.status[`RHC_ST_LINK] = 1'b1;
    end
    if (i_err_panel)
    begin
      d.status[`RHC_ST_PANEL] = 1'b1;
    end

    // Mode commands
    if (i_cmd_echo_on)
    begin
      d.echo = 1'b1;
    end
    else if (i_cmd_echo_off)
    begin
      d.echo = 1'b0;
      d.echo_rel = 1'b0;
    end
    if (!q.echo)
    begin
      d.ech_ptr = d.wr_ptr;
    end
    if (i_cmd_lock_on)
    begin
      d.lockout = 1'b1;
    end
    else if (i_cmd_lock_off)
    begin
      d.lockout = 1'b0;
    end

    // Modem line sequencing
    case (q.hs)
      rhc_pkg::RHC_HS_IDLE:
      begin
        if (pending && q.dtr && q.dsr_s[1])
        begin
          d.hs = rhc_pkg::RHC_HS_REQ;
        end
      end
      rhc_pkg::RHC_HS_REQ:
      begin
        if (q.cts_s[1])
        begin
          d.hs = rhc_pkg::RHC_HS_SEND;
        end
      end
      rhc_pkg::RHC_HS_SEND:
      begin
        // Wait for the shifter to empty so the last stop bit is not cut
        if (!pending && !q.txu_valid && i_txu_idle)
        begin
          d.hs = rhc_pkg::RHC_HS_CLEAR;
        end
      end
      rhc_pkg::RHC_HS_CLEAR:
      begin
        if (!q.cts_s[1] && !q.cd_s[1])
        begin
          d.hs = rhc_pkg::RHC_HS_IDLE;
        end
      end
      default:
      begin
        d.hs = rhc_pkg::RHC_HS_IDLE;
      end
    endcase
    if (!i_hs_full)
    begin
      d.hs = rhc_pkg::RHC_HS_IDLE;
    end
    d.rts = i_hs_full ?
      (d.hs == rhc_pkg::RHC_HS_REQ || d.hs == rhc_pkg::RHC_HS_SEND) : 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (wr_en)
    begin
      mem[q.wr_ptr] <= i_rx_char;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_txu_valid = q.txu_valid;
  assign o_txu_char = q.txu_char;
  assign o_tx_ack = q.tx_ack;
  assign o_rd_valid = q.rd_valid;
  assign o_rd_char = q.rd_char;
  assign o_dtr = q.dtr;
  assign o_rts = q.rts;
  assign o_lockout = q.lockout;
  assign o_echo = q.echo;
endmodule
`default_nettype wire

// ==== logic/rhc_fmt_if.sv ====
// Link between the controller and the status string formatter
`timescale 1ns/1ps
`default_nettype none
interface rhc_fmt_if;
  logic start;
  logic [7:0] value;
  logic take;
  logic valid;
  logic [7:0] chr;
  modport ctrl (output start, output value, output take, input valid, input chr);
  modport fmt (input start, input value, input take, output valid, output chr);
endinterface
`default_nettype wire

// ==== logic/rhc_pkg.sv ====
// Types shared by the handshake controller modules
package rhc_pkg;
  typedef enum logic [1:0] {
    RHC_HS_IDLE = 2'b00,
    RHC_HS_REQ = 2'b01,
    RHC_HS_SEND = 2'b10,
    RHC_HS_CLEAR = 2'b11
  } rhc_hs_e;
  typedef enum logic [1:0] {
    RHC_SW_NONE = 2'b00,
    RHC_SW_ENQ = 2'b01,
    RHC_SW_XON = 2'b10
  } rhc_sw_e;
endpackage

// ==== logic/rhc_status_fmt.sv ====
// Status word to decimal text formatter
`timescale 1ns/1ps
`default_nettype none
`include "rhc_cfg.svh"
module rhc_status_fmt (
  input wire logic i_clk,
  input wire logic i_rst,
  rhc_fmt_if.fmt fif
);
  typedef struct packed {
    logic active;
    logic [3:0] idx;
    logic [7:0] value;
  } rhc_fmt_s;

  rhc_fmt_s q;
  rhc_fmt_s d;
  logic [7:0] hun;
  logic [7:0] ten;
  logic [7:0] one;

  assign hun = q.value / 8'd100;
  assign ten = (q.value / 8'd10) % 8'd10;
  assign one = q.value % 8'd10;
  assign fif.valid = q.active;

  always_comb
  begin
    d = q;
    fif.chr = `RHC_CH_SP;
    case (q.idx)
      4'h0: fif.chr = `RHC_HDR_0;
      4'h1: fif.chr = `RHC_HDR_1;
      4'h2: fif.chr = `RHC_HDR_2;
      4'h3: fif.chr = `RHC_HDR_3;
      4'h4: fif.chr = `RHC_HDR_4;
      4'h5: fif.chr = `RHC_CH_SP;
      // Leading zeros become spaces
      4'h6: fif.chr = (hun == 8'h00) ? `RHC_CH_SP : `RHC_CH_ZERO + hun;
      4'h7: fif.chr = (hun == 8'h00 && ten == 8'h00) ? `RHC_CH_SP : `RHC_CH_ZERO + ten;
      4'h8: fif.chr = `RHC_CH_ZERO + one;
      4'h9: fif.chr = `RHC_CH_CR;
      4'hA: fif.chr = `RHC_CH_LF;
      default: fif.chr = `RHC_CH_SP;
    endcase
    if (!q.active && fif.start)
    begin
      d.active = 1'b1;
      d.idx = 4'h0;
      d.value = fif.value;
    end
    else if (q.active && fif.take)
    begin
      d.idx = q.idx + 4'h1;
      if (q.idx == `RHC_FMT_LAST)
      begin
        d.active = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ==== tb/rhc_ctrl_props.sv ====
// Port assertions for the handshake controller
`timescale 1ns/1ps
`default_nettype none
module rhc_ctrl_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hs_full,
  input wire logic i_ready,
  input wire logic i_dsr,
  input wire logic i_cts,
  input wire logic i_cd,
  input wire logic i_tx_valid,
  input wire logic i_txu_ready,
  input wire logic i_txu_idle,
  input wire logic i_cmd_echo_on,
  input wire logic i_cmd_echo_off,
  input wire logic i_cmd_lock_on,
  input wire logic i_cmd_lock_off,
  input wire logic o_txu_valid,
  input wire logic [7:0] o_txu_char,
  input wire logic o_dtr,
  input wire logic o_rts,
  input wire logic o_lockout,
  input wire logic o_echo
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  a_none_lines_up: assert property (
    !i_hs_full && !$past(i_hs_full) && !$past(i_rst) |-> o_dtr && o_rts)
    else $error("control lines low without hardware handshake");
  a_full_dtr_ready: assert property (
    i_hs_full && $past(i_hs_full) && !$past(i_rst) |-> o_dtr == $past(i_ready))
    else $error("terminal ready does not follow operational state");
  a_send_gate: assert property (
    i_hs_full && $rose(o_txu_valid) |-> o_rts && o_dtr && $past(i_cts, 3) && $past(i_dsr, 3))
    else $error("character offered without request and clear to send");
  a_rts_drop_done: assert property (
    i_hs_full && o_rts && !o_txu_valid && i_txu_idle && !i_tx_valid && $past(i_cts, 3)
    |-> ##[1:2] !o_rts)
    else $error("request to send held after transmission");
  a_rts_rearm_gap: assert property (
    i_hs_full && $rose(o_rts) && !$past(i_rst) |-> !$past(i_cts, 2) && !$past(i_cd, 2))
    else $error("request to send raised before modem released line");
  a_echo_cmd: assert property (
    i_cmd_echo_on || i_cmd_echo_off |=> o_echo == $past(i_cmd_echo_on))
    else $error("echo mode not set by command");
  a_echo_hold: assert property (
    !$past(i_cmd_echo_on) && !$past(i_cmd_echo_off) && !$past(i_rst) |-> $stable(o_echo))
    else $error("echo mode changed without command");
  a_lock_cmd: assert property (
    i_cmd_lock_on || i_cmd_lock_off |=> o_lockout == $past(i_cmd_lock_on))
    else $error("lockout not set by command");
  a_reset_clear: assert property (
    $past(i_rst) |-> !o_echo && !o_lockout)
    else $error("modes survive reset");
  c_rts_up: cover property (i_hs_full && $rose(o_rts));
  c_echo_on: cover property ($rose(o_echo));
  c_xoff_out: cover property (o_txu_valid && i_txu_ready && o_txu_char == 8'h13);
endmodule
bind rhc_ctrl rhc_ctrl_props rhc_ctrl_props_inst (.i_clk, .i_rst, .i_hs_full, .i_ready,
  .i_dsr, .i_cts, .i_cd, .i_tx_valid, .i_txu_ready, .i_txu_idle, .i_cmd_echo_on,
  .i_cmd_echo_off, .i_cmd_lock_on, .i_cmd_lock_off, .o_txu_valid, .o_txu_char, .o_dtr,
  .o_rts, .o_lockout, .o_echo);
`default_nettype wire

// ==== tb/rhc_modem.sv ====
// Modem and transmit shifter model on the far side
`timescale 1ns/1ps
`default_nettype none
module rhc_modem (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_rts,
  input wire logic i_txu_valid,
  input wire logic i_carrier,
  output logic o_dsr,
  output logic o_cts,
  output logic o_cd,
  output logic o_txu_ready,
  output logic o_txu_idle
);
  logic [2:0] on_cnt = 3'h0;
  logic [2:0] off_cnt = 3'h0;
  logic [2:0] busy = 3'h0;
  logic phase = 1'b0;
  logic took = 1'b0;
  initial
  begin
    o_dsr = 1'b1;
    o_cts = 1'b0;
    o_cd = 1'b0;
    o_txu_ready = 1'b0;
    o_txu_idle = 1'b1;
  end
  always @(posedge i_clk)
    took <= i_txu_valid && o_txu_ready;
  always @(negedge i_clk)
  begin
    on_cnt <= i_rts ? on_cnt + {2'h0, on_cnt != 3'h7} : 3'h0;
    off_cnt <= i_rts ? 3'h0 : off_cnt + {2'h0, off_cnt != 3'h7};
    // Slow release of clear to send exercises the re-arm wait
    o_cts <= (on_cnt >= 3'h3) || (o_cts && off_cnt < 3'h3);
    // Carrier only while the line is turned toward us
    o_cd <= i_carrier && !i_rts;
    phase <= !phase;
    busy <= took ? (i_slow ? 3'h6 : 3'h2) : busy - {2'h0, busy != 3'h0};
    o_txu_ready <= !took && busy == 3'h0 && !(i_slow && phase);
    o_txu_idle <= !took && busy == 3'h0;
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the handshake controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_hs_full = 1'b0;
  logic [1:0] i_sw_mode = 2'b00;
  logic i_full_duplex = 1'b1;
  logic i_dsr, i_cts, i_cd, i_txu_ready, i_txu_idle;
  logic i_rx_valid = 1'b0;
  logic [7:0] i_rx_char = 8'h00;
  logic pe = 1'b0;
  logic fe = 1'b0;
  logic i_tx_valid = 1'b0;
  logic [7:0] i_tx_char = 8'h00;
  logic i_rd_ready = 1'b0;
  logic [4:0] cmd = 5'h00;
  logic [3:0] err = 4'h0;
  logic slow = 1'b0;
  logic rdy = 1'b1;
  logic carrier = 1'b0;
  logic [7:0] rc;
  logic seen;
  logic o_txu_valid, o_tx_ack, o_rd_valid, o_dtr, o_rts, o_lockout, o_echo;
  logic [7:0] o_txu_char, o_rd_char;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'hABBF50E2;
  int n_mismatch = 0;
  int check_count = 0;
  int k;
  rhc_ctrl rhc_ctrl_inst (.i_clk, .i_rst, .i_hs_full, .i_sw_mode, .i_full_duplex,
    .i_ready(rdy), .i_dsr, .i_cts, .i_cd, .i_rx_valid, .i_rx_char, .i_rx_parity_err(pe),
    .i_rx_frame_err(fe), .i_txu_ready, .i_txu_idle, .o_txu_valid, .o_txu_char, .i_tx_valid,
    .i_tx_char, .o_tx_ack, .o_rd_valid, .o_rd_char, .i_rd_ready, .i_cmd_echo_on(cmd[0]),
    .i_cmd_echo_off(cmd[1]), .i_cmd_lock_on(cmd[2]), .i_cmd_lock_off(cmd[3]),
    .i_cmd_status(cmd[4]), .i_err_keycode(err[0]), .i_err_locked(err[1]),
    .i_err_link(err[2]), .i_err_panel(err[3]), .o_dtr, .o_rts, .o_lockout, .o_echo);
  rhc_modem rhc_modem_inst (.i_clk, .i_slow(slow), .i_rts(o_rts), .i_txu_valid(o_txu_valid),
    .i_carrier(carrier),
    .o_dsr(i_dsr), .o_cts(i_cts), .o_cd(i_cd), .o_txu_ready(i_txu_ready),
    .o_txu_idle(i_txu_idle));
  initial
  begin
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return {2'b01, seed[5:0]};
  endfunction
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic rx(input logic [7:0] c, input logic p, input logic f);
    cyc(1);
    i_rx_valid = 1'b1;
    i_rx_char = c;
    pe = p;
    fe = f;
    cyc(1);
    i_rx_valid = 1'b0;
    pe = 1'b0;
    fe = 1'b0;
  endtask
  task automatic pulse(input int b);
    cyc(1);
    cmd[b] = 1'b1;
    cyc(1);
    cmd = 5'h00;
  endtask
  task automatic wait_ack;
    for (int i = 0; i < 300; i++)
    begin
      @(posedge i_clk);
      #1;
      if (o_tx_ack === 1'b1)
        break;
    end
    cyc(1);
    i_tx_valid = 1'b0;
  endtask
  task automatic send(input logic [7:0] c);
    exp_q.push_back(c);
    cyc(1);
    i_tx_valid = 1'b1;
    i_tx_char = c;
    wait_ack;
  endtask
  task automatic drain;
    for (int i = 0; i < 600 && exp_q.size() != 0; i++)
      cyc(1);
    chk("txu_left", 8'h00, 8'(exp_q.size()));
  endtask
  task automatic status(input logic [7:0] d2, input logic [7:0] d1, input logic [7:0] d0);
    logic [7:0] s [11];
    s = '{8'h53, 8'h54, 8'h53, 8'h57, 8'h44, 8'h20, d2, d1, d0, 8'h0D, 8'h0A};
    foreach (s[i])
      exp_q.push_back(s[i]);
    pulse(4);
    drain;
  endtask
  // Transmit stream: the oldest note is taken off whenever a character leaves
  always @(posedge i_clk)
  begin
    if (!i_rst && o_txu_valid === 1'b1 && i_txu_ready === 1'b1)
      chk("txu_char", exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX, o_txu_char);
  end
  initial
  begin
    #1000000;
    n_mismatch++;
    end_of_test;
  end
  initial
  begin
    cyc(10);
    i_rst = 1'b0;
    cyc(2);
    chk("dtr", 8'h01, {7'h00, o_dtr});
    chk("rts", 8'h01, {7'h00, o_rts});
    err = 4'hF;
    cyc(1);
    err = 4'h0;
    rx(rnd(), 1'b1, 1'b0);
    rx(rnd(), 1'b0, 1'b1);
    status(8'h31, 8'h31, 8'h31);
    status(8'h20, 8'h20, 8'h30);
    pulse(2);
    chk("lockout", 8'h01, {7'h00, o_lockout});
    pulse(3);
    chk("lockout", 8'h00, {7'h00, o_lockout});
    pulse(0);
    exp_q.push_back(rnd());
    rx(exp_q[0], 1'b0, 1'b0);
    drain;
    pulse(1);
    i_rd_ready = 1'b1;
    cyc(20);
    i_rd_ready = 1'b0;
    // Flow control: stop character at 32 buffered, start character at ten, received stop character pauses sending
    i_sw_mode = 2'b10;
    slow = seed[7];
    // One character waits in the read-out register and is not counted
    for (k = 0; k < 33; k++)
    begin
      if (k == 32)
        exp_q.push_back(8'h13);
      rx(rnd(), 1'b0, 1'b0);
      cyc(2);
    end
    drain;
    for (k = 0; k < 22; k++)
    begin
      if (k == 21)
        exp_q.push_back(8'h11);
      for (int i = 0; i < 50 && o_rd_valid !== 1'b1; i++)
        cyc(1);
      i_rd_ready = 1'b1;
      cyc(1);
      i_rd_ready = 1'b0;
      cyc(8);
    end
    drain;
    i_rd_ready = 1'b1;
    rx(8'h13, 1'b0, 1'b0);
    exp_q.push_back(rnd());
    i_tx_valid = 1'b1;
    i_tx_char = exp_q[0];
    seen = 1'b0;
    repeat (20)
    begin
      @(posedge i_clk);
      #1;
      seen = seen | o_tx_ack;
    end
    chk("tx_paused", 8'h00, {7'h00, seen});
    rx(8'h11, 1'b0, 1'b0);
    wait_ack;
    drain;
    i_sw_mode = 2'b01;
    i_full_duplex = 1'b0;
    exp_q.push_back(8'h06);
    rx(8'h05, 1'b0, 1'b0);
    drain;
    exp_q.push_back(8'h05);
    exp_q.push_back(rnd());
    i_tx_valid = 1'b1;
    i_tx_char = exp_q[1];
    for (k = 0; k < 300 && exp_q.size() > 1; k++)
      cyc(1);
    cyc(10);
    chk("enq_wait", 8'h01, 8'(exp_q.size()));
    rx(8'h06, 1'b0, 1'b0);
    wait_ack;
    drain;
    // Half-duplex echo holds the string until the line feed
    i_sw_mode = 2'b00;
    pulse(0);
    exp_q.push_back(rnd());
    exp_q.push_back(8'h0A);
    rx(exp_q[0], 1'b0, 1'b0);
    cyc(6);
    chk("echo_wait", 8'h02, 8'(exp_q.size()));
    rx(8'h0A, 1'b0, 1'b0);
    drain;
    pulse(1);
    // Full modem handshake from a fresh reset
    i_rst = 1'b1;
    i_hs_full = 1'b1;
    i_sw_mode = 2'b00;
    i_full_duplex = 1'b1;
    slow = seed[3];
    cyc(2);
    i_rst = 1'b0;
    cyc(2);
    chk("dtr", 8'h01, {7'h00, o_dtr});
    chk("rts", 8'h00, {7'h00, o_rts});
    rdy = 1'b0;
    cyc(3);
    chk("dtr", 8'h00, {7'h00, o_dtr});
    rdy = 1'b1;
    cyc(3);
    for (k = 0; k < 3; k++)
      send(rnd());
    drain;
    cyc(20);
    chk("rts", 8'h00, {7'h00, o_rts});
    send(rnd());
    drain;
    // Consumer stalls so that a wrongly stored character would stay visible
    i_rd_ready = 1'b0;
    rx(rnd(), 1'b0, 1'b0);
    cyc(6);
    chk("rd_valid", 8'h00, {7'h00, o_rd_valid});
    carrier = 1'b1;
    cyc(4);
    rc = rnd();
    rx(rc, 1'b0, 1'b0);
    cyc(6);
    chk("rd_valid", 8'h01, {7'h00, o_rd_valid});
    chk("rd_char", rc, o_rd_char);
    carrier = 1'b0;
    end_of_test;
  end
endmodule
`default_nettype wire
